// ---- rtl/cfairq_top.sv ----
// Charger fault and alarm interrupt logic behind a serial register port
`timescale 1ns/100ps
module cfairq_top #(
  parameter logic [6:0] DEV_ADDR = cfairq_pkg::CFAIRQ_DEV_ADDR
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // Serial register port pins
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n,
  // Register reset command, one-cycle pulse
  input  wire logic                     reg_rst_req,
  // Fault comparator levels, asynchronous
  input  wire cfairq_pkg::cfairq_flt_t  fault_raw,
  // Alarm and insertion events, one-cycle pulses
  input  wire cfairq_pkg::cfairq_evt_t  evt_pulse,
  // Clear of pending events by the event flag reader
  input  wire logic                     evt_clr_en,
  input  wire cfairq_pkg::cfairq_evt_t  evt_clr_bits,
  // Interrupt line, active low
  output logic                          irq_n
);

  import cfairq_pkg::*;

  // Synchronised pins and fault levels
  logic [1:0]    pins_n_s;        // {scl, sda} inverted, after two flops
  logic          scl_s;           // Clean clock line
  logic          sda_s;           // Clean data line
  cfairq_flt_t   flt_live;        // Present fault conditions
  logic          scl_prev_ff;     // Clock line one cycle ago
  logic          sda_prev_ff;     // Data line one cycle ago

  // Line events
  logic          scl_rise;        // Clock rising edge
  logic          scl_fall;        // Clock falling edge
  logic          bus_start;       // Start or repeated start
  logic          bus_stop;        // Stop condition

  // Byte engine state
  cfairq_state_t state_ff;        // Engine state
  cfairq_state_t nxt_state;
  logic [3:0]    cnt_ff;          // Bits moved in this byte
  logic [3:0]    nxt_cnt;
  logic [7:0]    shift_ff;        // Serial shift register
  logic [7:0]    nxt_shift;
  logic [7:0]    ptr_ff;          // Register pointer
  logic [7:0]    nxt_ptr;
  logic          rnw_ff;          // Read transfer selected
  logic          nxt_rnw;
  logic          pull_ff;         // Pulling data line low
  logic          nxt_pull;
  logic          mnack_ff;        // Master declined next byte
  logic          nxt_mnack;
  logic          wr_en;           // Write byte strobe
  logic          rd_load;         // Read byte fetched

  // Register file
  cfairq_evt_t   evt_gate_ff;     // event_irq_gate
  cfairq_evt_t   nxt_evt_gate;
  cfairq_flt_t   flt_gate_ff;     // fault_irq_gate
  cfairq_flt_t   nxt_flt_gate;
  logic [7:0]    flt_latched;     // fault_latched_events
  logic [7:0]    evt_pend;        // Pending alarm events
  logic [7:0]    rd_data;         // Read mux output
  logic          flt_rd_clr;      // Latched faults read
  logic          irq_n_ff;        // Registered interrupt line
  logic          irq_req;         // Some unmasked flag set

  // Pins cross inverted, so the flops reset to the idle-high level
  cfairq_sync #(
    .W (2)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (~{scl_in, sda_in}),
    .q       (pins_n_s)
  );

  // Live faults, unlatched, after two flops
  cfairq_sync #(
    .W (8)
  ) u_flt_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (fault_raw),
    .q       (flt_live)
  );

  assign scl_s = ~pins_n_s[1];
  assign sda_s = ~pins_n_s[0];

  // Previous line levels, idle lines are high
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end

  // Edge and condition decode on clean lines
  assign scl_rise  = scl_s & ~scl_prev_ff;
  assign scl_fall  = ~scl_s & scl_prev_ff;
  assign bus_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

  // Read mux; unmapped offsets read zero
  assign rd_data =
    (ptr_ff == CFAIRQ_OFS_EVT_GATE)  ? evt_gate_ff :
    (ptr_ff == CFAIRQ_OFS_FLT_LIVE)  ? flt_live    :
    (ptr_ff == CFAIRQ_OFS_FLT_LATCH) ? flt_latched :
    (ptr_ff == CFAIRQ_OFS_FLT_GATE)  ? flt_gate_ff :
    CFAIRQ_RD_UNMAPPED;

  // Fetching the latched byte clears exactly what was sent
  assign flt_rd_clr = rd_load & (ptr_ff == CFAIRQ_OFS_FLT_LATCH);

  // Byte engine: address, pointer, write and read phases
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr   = ptr_ff;
    nxt_rnw   = rnw_ff;
    nxt_pull  = pull_ff;
    nxt_mnack = mnack_ff;
    wr_en     = 1'b0;
    rd_load   = 1'b0;
    if (bus_start) begin
      // Start restarts the address phase anywhere
      nxt_state = CFAIRQ_ST_ADDR;
      nxt_cnt   = CFAIRQ_CNT_CLEAR;
      nxt_pull  = 1'b0;
    end else if (bus_stop) begin
      // Stop frees the line
      nxt_state = CFAIRQ_ST_IDLE;
      nxt_pull  = 1'b0;
    end else begin
      case (state_ff)
        CFAIRQ_ST_IDLE: begin
          nxt_pull = 1'b0;
        end
        CFAIRQ_ST_ADDR, CFAIRQ_ST_PTR, CFAIRQ_ST_WDAT: begin
          if (scl_rise) begin
            // Sample a bit, msb first
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt   = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == CFAIRQ_BITS_PER_BYTE) begin
            nxt_cnt = CFAIRQ_CNT_CLEAR;
            if (state_ff == CFAIRQ_ST_ADDR) begin
              // Answer only our own address
              if (shift_ff[7:1] == DEV_ADDR) begin
                nxt_rnw   = shift_ff[0];
                nxt_pull  = 1'b1;
                nxt_state = CFAIRQ_ST_AACK;
              end else begin
                nxt_state = CFAIRQ_ST_IDLE;
              end
            end else if (state_ff == CFAIRQ_ST_PTR) begin
              nxt_ptr   = shift_ff;
              nxt_pull  = 1'b1;
              nxt_state = CFAIRQ_ST_PACK;
            end else begin
              // Data byte goes to the pointed register
              wr_en     = 1'b1;
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_pull  = 1'b1;
              nxt_state = CFAIRQ_ST_WACK;
            end
          end
        end
        CFAIRQ_ST_AACK: begin
          if (scl_fall) begin
            if (rnw_ff) begin
              // First read byte, msb driven at once
              rd_load   = 1'b1;
              nxt_shift = {rd_data[6:0], 1'b0};
              nxt_pull  = ~rd_data[7];
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_cnt   = CFAIRQ_CNT_FIRST_TX;
              nxt_state = CFAIRQ_ST_RDAT;
            end else begin
              nxt_pull  = 1'b0;
              nxt_state = CFAIRQ_ST_PTR;
            end
          end
        end
        CFAIRQ_ST_PACK, CFAIRQ_ST_WACK: begin
          if (scl_fall) begin
            nxt_pull  = 1'b0;
            nxt_state = CFAIRQ_ST_WDAT;
          end
        end
        CFAIRQ_ST_RDAT: begin
          if (scl_fall) begin
            if (cnt_ff == CFAIRQ_BITS_PER_BYTE) begin
              // Release for the master's answer
              nxt_pull  = 1'b0;
              nxt_state = CFAIRQ_ST_RACK;
            end else begin
              nxt_pull  = ~shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_cnt   = cnt_ff + 4'h1;
            end
          end
        end
        CFAIRQ_ST_RACK: begin
          if (scl_rise) begin
            nxt_mnack = sda_s;
          end else if (scl_fall) begin
            if (mnack_ff) begin
              nxt_state = CFAIRQ_ST_IDLE;
            end else begin
              // Next byte from the next offset
              rd_load   = 1'b1;
              nxt_shift = {rd_data[6:0], 1'b0};
              nxt_pull  = ~rd_data[7];
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_cnt   = CFAIRQ_CNT_FIRST_TX;
              nxt_state = CFAIRQ_ST_RDAT;
            end
          end
        end
        default: begin
          nxt_state = CFAIRQ_ST_IDLE;
          nxt_pull  = 1'b0;
        end
      endcase
    end
  end

  // Byte engine registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= CFAIRQ_ST_IDLE;
      cnt_ff   <= CFAIRQ_CNT_CLEAR;
      shift_ff <= 8'h00;
      ptr_ff   <= CFAIRQ_RST_PTR;
      rnw_ff   <= 1'b0;
      pull_ff  <= 1'b0;
      mnack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff   <= nxt_ptr;
      rnw_ff   <= nxt_rnw;
      pull_ff  <= nxt_pull;
      mnack_ff <= nxt_mnack;
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~pull_ff;

  // Gate registers: writable, cleared by the register reset command
  assign nxt_evt_gate =
    reg_rst_req ? CFAIRQ_RST_GATE :
    (wr_en && ptr_ff == CFAIRQ_OFS_EVT_GATE) ? shift_ff :
    evt_gate_ff;
  assign nxt_flt_gate =
    reg_rst_req ? CFAIRQ_RST_GATE :
    (wr_en && ptr_ff == CFAIRQ_OFS_FLT_GATE) ? shift_ff :
    flt_gate_ff;

  // Gate storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      evt_gate_ff <= CFAIRQ_RST_GATE;
      flt_gate_ff <= CFAIRQ_RST_GATE;
    end else begin
      evt_gate_ff <= nxt_evt_gate;
      flt_gate_ff <= nxt_flt_gate;
    end
  end

  // Latched faults: set while a fault is present, cleared by a read
  cfairq_sticky #(
    .W (8)
  ) u_flt_latch (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .set_bits (flt_live),
    .clr_en   (flt_rd_clr),
    .clr_bits (rd_data),
    .flags    (flt_latched)
  );

  // Pending alarm and insertion events until their reader clears them
  cfairq_sticky #(
    .W (8)
  ) u_evt_pend (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .set_bits (evt_pulse),
    .clr_en   (evt_clr_en),
    .clr_bits (evt_clr_bits),
    .flags    (evt_pend)
  );

  // Each gate bit masks only its own source, same bit order
  assign irq_req = |(evt_pend & ~evt_gate_ff)
                 | |(flt_latched & ~flt_gate_ff);

  // Interrupt line, low while an unmasked flag is held
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= ~irq_req;
    end
  end

  assign irq_n = irq_n_ff;

endmodule

// ---- rtl/cfairq_pkg.sv ----
// Shared constants, field layouts and types of the charger fault alarm block
package cfairq_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] CFAIRQ_OFS_EVT_GATE   = 8'h0f; // event_irq_gate
  localparam logic [7:0] CFAIRQ_OFS_FLT_LIVE   = 8'h10; // fault_live_state
  localparam logic [7:0] CFAIRQ_OFS_FLT_LATCH  = 8'h11; // fault_latched_events
  localparam logic [7:0] CFAIRQ_OFS_FLT_GATE   = 8'h12; // fault_irq_gate

  // Values after reset and read-back of unmapped offsets
  localparam logic [7:0] CFAIRQ_RST_GATE       = 8'h00;
  localparam logic [7:0] CFAIRQ_RST_FLAGS      = 8'h00;
  localparam logic [7:0] CFAIRQ_RD_UNMAPPED    = 8'h00;
  localparam logic [7:0] CFAIRQ_RST_PTR        = 8'h00;

  // Serial slave address; value is arbitrary
  localparam logic [6:0] CFAIRQ_DEV_ADDR       = 7'h2a;

  // Bit counts of the serial byte engine
  localparam logic [3:0] CFAIRQ_BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] CFAIRQ_CNT_CLEAR      = 4'h0;
  localparam logic [3:0] CFAIRQ_CNT_FIRST_TX   = 4'h1;

  // Fault source bits, msb first; gate bits use the same order
  typedef struct packed {
    logic batt_overvolt;          // Bit 7
    logic batt_overcurr;          // Bit 6
    logic bus_overvolt;           // Bit 5
    logic bus_overcurr;           // Bit 4
    logic temp_sense_near_limit;  // Bit 3
    logic cell_temp_fault;        // Bit 2
    logic connector_temp_fault;   // Bit 1
    logic die_heat;               // Bit 0
  } cfairq_flt_t;

  // Alarm and insertion event bits, msb first
  typedef struct packed {
    logic batt_overvolt_alarm;    // Bit 7
    logic batt_overcurr_alarm;    // Bit 6
    logic bus_overvolt_alarm;     // Bit 5
    logic bus_overcurr_alarm;     // Bit 4
    logic batt_undercurr_alarm;   // Bit 3
    logic supply_attach;          // Bit 2
    logic cell_attach;            // Bit 1
    logic conv_done;              // Bit 0
  } cfairq_evt_t;

  // Serial slave byte engine states
  typedef enum logic [3:0] {
    CFAIRQ_ST_IDLE  = 4'b0000,
    CFAIRQ_ST_ADDR  = 4'b0001,
    CFAIRQ_ST_AACK  = 4'b0010,
    CFAIRQ_ST_PTR   = 4'b0011,
    CFAIRQ_ST_PACK  = 4'b0100,
    CFAIRQ_ST_WDAT  = 4'b0101,
    CFAIRQ_ST_WACK  = 4'b0110,
    CFAIRQ_ST_RDAT  = 4'b0111,
    CFAIRQ_ST_RACK  = 4'b1000
  } cfairq_state_t;

endpackage

// ---- rtl/cfairq_sync.sv ----
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module cfairq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_ff; // Only read by stage2_ff
  logic [W-1:0] stage2_ff; // Safe to use

  // Two stages; first stage feeds nothing but the second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= d;
      stage2_ff <= stage1_ff;
    end
  end

  assign q = stage2_ff;

endmodule

// ---- rtl/cfairq_sticky.sv ----
// Sticky flag bank: set by events, cleared selectively, set wins
`timescale 1ns/100ps
module cfairq_sticky #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Set and clear
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clr_en,
  input  wire logic [W-1:0] clr_bits,
  // Held flags
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_ff;     // Held flags
  logic [W-1:0] nxt_flags;    // Next flags
  logic [W-1:0] clr_mask;     // Bits cleared this cycle

  // Clear only what was asked; a set in the same cycle survives
  assign clr_mask  = clr_en ? clr_bits : '0;
  assign nxt_flags = set_bits | (flags_ff & ~clr_mask);

  // Flag storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule

// ---- tb/cfairq_chk.sv ----
// Port-level assertions of the charger fault alarm interrupt block
`timescale 1ns/100ps
module cfairq_chk (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    nrst,
  // Serial pins
  input wire logic                    scl_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe_n,
  // Causes of interrupt line changes
  input wire logic                    reg_rst_req,
  input wire cfairq_pkg::cfairq_flt_t fault_raw,
  input wire cfairq_pkg::cfairq_evt_t evt_pulse,
  input wire logic                    evt_clr_en,
  // Interrupt line
  input wire logic                    irq_n
);
  import cfairq_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [3:0] set_age_ff; // Cycles since a cause for a low line
  logic [3:0] clr_age_ff; // Cycles since a cause for a release
  logic       frame_ff;   // A serial transfer is open
  logic       scl_d_ff;   // Clock pin one cycle ago
  logic       sda_d_ff;   // Data pin one cycle ago
  // Bus activity covers gate writes and clearing reads
  wire logic set_cause = (|evt_pulse) || (|fault_raw) || !scl_in
                         || reg_rst_req;
  wire logic clr_cause = evt_clr_en || !scl_in;
  wire logic start_seen = scl_d_ff && scl_in && sda_d_ff && !sda_in;
  wire logic stop_seen = scl_d_ff && scl_in && !sda_d_ff && sda_in;
  // Saturating ages
  wire logic [3:0] nxt_set_age = set_cause ? 4'h0
                                 : set_age_ff + {3'h0, ~&set_age_ff};
  wire logic [3:0] nxt_clr_age = clr_cause ? 4'h0
                                 : clr_age_ff + {3'h0, ~&clr_age_ff};
  // Helper registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      set_age_ff <= 4'h0;
      clr_age_ff <= 4'h0;
      frame_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      set_age_ff <= nxt_set_age;
      clr_age_ff <= nxt_clr_age;
      frame_ff <= start_seen || (frame_ff && !stop_seen);
      scl_d_ff <= scl_in;
      sda_d_ff <= sda_in;
    end
  end
  sequence s_pull_hold;
    !sda_oe_n [*8];
  endsequence
  sequence s_quiet;
    irq_n [*2];
  endsequence
  property p_sda_value;
    sda_out == 1'b0;
  endproperty
  a_sda_value: assert property (p_sda_value)
    else $error("data pin value not low");
  property p_pull_scl_low;
    $fell(sda_oe_n) |-> !scl_in;
  endproperty
  a_pull_scl_low: assert property (p_pull_scl_low)
    else $error("data pulled while clock high");
  property p_release_scl_low;
    $rose(sda_oe_n) |-> !scl_in;
  endproperty
  a_release_scl_low: assert property (p_release_scl_low)
    else $error("data released while clock high");
  property p_pull_in_frame;
    !sda_oe_n |-> frame_ff;
  endproperty
  a_pull_in_frame: assert property (p_pull_in_frame)
    else $error("data pulled outside a transfer");
  property p_pull_holds;
    $fell(sda_oe_n) |-> s_pull_hold;
  endproperty
  a_pull_holds: assert property (p_pull_holds)
    else $error("driven bit too short");
  property p_quiet_after_reset;
    $rose(nrst) |-> s_quiet;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset)
    else $error("interrupt low right after reset");
  property p_fall_has_cause;
    $fell(irq_n) |-> set_age_ff < 4'h8;
  endproperty
  a_fall_has_cause: assert property (p_fall_has_cause)
    else $error("interrupt fell without a cause");
  property p_rise_has_cause;
    $rose(irq_n) |-> clr_age_ff < 4'h8;
  endproperty
  a_rise_has_cause: assert property (p_rise_has_cause)
    else $error("interrupt released without a clear");
endmodule
bind cfairq_top cfairq_chk cfairq_chk_inst (.clk_sys, .nrst, .scl_in,
  .sda_in, .sda_out, .sda_oe_n, .reg_rst_req, .fault_raw, .evt_pulse,
  .evt_clr_en, .irq_n);

// ---- tb/cfairq_host.sv ----
// Serial register host model with open-drain data line resolution
`timescale 1ns/100ps
module cfairq_host (
  // Clock
  input  wire logic clk_sys,
  // Device data pin
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  // Resolved bus lines
  output logic      scl,
  output logic      sda
);
  import cfairq_pkg::*;
  logic low_ff; // Host pulls data low
  int   nacks;  // Bytes the device failed to acknowledge
  // Pull-up wins unless a party pulls low
  assign sda = !(low_ff || (!sda_oe_n && !sda_out));
  initial begin
    scl = 1'b1;
    low_ff = 1'b0;
    nacks = 0;
  end
  // Wait clock edges
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Data moves only while clock is low
  task automatic bit_io(input logic b, output logic r);
    tk(3);
    low_ff <= !b;
    tk(7);
    scl <= 1'b1;
    tk(10);
    r = sda;
    scl <= 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    tk(3);
    low_ff <= 1'b0;
    tk(7);
    scl <= 1'b1;
    tk(10);
    low_ff <= 1'b1;
    tk(10);
    scl <= 1'b0;
  endtask
  // Stop leaves both lines high
  task automatic stop();
    tk(3);
    low_ff <= 1'b1;
    tk(7);
    scl <= 1'b1;
    tk(10);
    low_ff <= 1'b0;
    tk(10);
  endtask
  // Eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic m_ack,
                      output logic [7:0] r, output logic s_ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(m_ack, s_ack);
  endtask
  // Byte that the device must acknowledge
  task automatic put(input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    xfer(d, 1'b1, r, a);
    if (a !== 1'b0) nacks++;
  endtask
  // Register write
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    start();
    put({CFAIRQ_DEV_ADDR, 1'b0});
    put(ofs);
    put(v);
    stop();
  endtask
  // Register read through a repeated start, closed by a refusal
  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    logic a;
    start();
    put({CFAIRQ_DEV_ADDR, 1'b0});
    put(ofs);
    start();
    put({CFAIRQ_DEV_ADDR, 1'b1});
    xfer(8'hff, 1'b1, v, a);
    stop();
  endtask
  // Two data bytes in one write; the pointer steps between them
  task automatic wr_pair(input logic [7:0] ofs, input logic [7:0] v0,
                         input logic [7:0] v1);
    start();
    put({CFAIRQ_DEV_ADDR, 1'b0});
    put(ofs);
    put(v0);
    put(v1);
    stop();
  endtask
  // Two bytes in one read, the first acknowledged by the host
  task automatic rd_pair(input logic [7:0] ofs, output logic [7:0] v0,
                         output logic [7:0] v1);
    logic a;
    start();
    put({CFAIRQ_DEV_ADDR, 1'b0});
    put(ofs);
    start();
    put({CFAIRQ_DEV_ADDR, 1'b1});
    xfer(8'hff, 1'b0, v0, a);
    xfer(8'hff, 1'b1, v1, a);
    stop();
  endtask
endmodule

// ---- tb/charger_fault_alarm_irq_test.sv ----
// Self-checking bench of the charger fault alarm interrupt block
`timescale 1ns/100ps
`define CHK(got, e) \
  begin \
    samples_checked++; \
    if ((got) !== (e)) begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, e); \
    end \
  end
module charger_fault_alarm_irq_test;
  import cfairq_pkg::*;
  logic        clk_sys = 1'b0; // System clock
  logic        nrst;           // Reset, active low
  logic        reg_rst_req;    // Gate reset command
  cfairq_flt_t fault_raw;      // Fault levels
  cfairq_evt_t evt_pulse;      // Event pulses
  logic        evt_clr_en;     // Pending clear
  cfairq_evt_t evt_clr_bits;   // Bits to clear
  logic        scl, sda;       // Bus lines
  logic        sda_out, sda_oe_n, irq_n;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h966294f6;
  logic [7:0]  m_eg, m_fg, m_pend, m_lat; // Reference model state
  always #5 clk_sys = ~clk_sys;
  cfairq_top cfairq_top_inst (.clk_sys(clk_sys), .nrst(nrst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .reg_rst_req(reg_rst_req), .fault_raw(fault_raw),
    .evt_pulse(evt_pulse), .evt_clr_en(evt_clr_en),
    .evt_clr_bits(evt_clr_bits), .irq_n(irq_n));
  cfairq_host cfairq_host_inst (.clk_sys(clk_sys), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  // Xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Read a register and compare
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] v;
    cfairq_host_inst.rd(ofs, v);
    `CHK(v, e)
  endtask
  // Line is low exactly when an unmasked flag is held
  task automatic irq_chk();
    tk(4);
    `CHK(irq_n, ~|((m_pend & ~m_eg) | (m_lat & ~m_fg)))
  endtask
  // Event pulse or pending clear, one cycle
  task automatic evt(input logic [7:0] p, input logic clr);
    @(posedge clk_sys);
    evt_pulse <= clr ? 8'h00 : p;
    evt_clr_en <= clr;
    evt_clr_bits <= p;
    @(posedge clk_sys);
    evt_pulse <= 8'h00;
    evt_clr_en <= 1'b0;
    m_pend = clr ? (m_pend & ~p) : (m_pend | p);
  endtask
  // Counts and verdict
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    tk(90000);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
  // Main sequence
  initial begin
    logic [7:0] v, f;
    logic       a;
    nrst = 1'b0;
    reg_rst_req = 1'b0;
    fault_raw = 8'h00;
    evt_pulse = 8'h00;
    evt_clr_en = 1'b0;
    evt_clr_bits = 8'h00;
    {m_eg, m_fg, m_pend, m_lat} = 32'h0;
    tk(12);
    nrst <= 1'b1;
    tk(4);
    rd_chk(CFAIRQ_OFS_EVT_GATE, CFAIRQ_RST_GATE);
    rd_chk(CFAIRQ_OFS_FLT_GATE, CFAIRQ_RST_GATE);
    rd_chk(8'h20, CFAIRQ_RD_UNMAPPED);
    irq_chk();
    // A foreign address is not acknowledged
    cfairq_host_inst.start();
    cfairq_host_inst.xfer({CFAIRQ_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, v, a);
    cfairq_host_inst.stop();
    `CHK(a, 1'b1)
    // Gates read back; the live register ignores writes
    m_eg = rnd();
    cfairq_host_inst.wr(CFAIRQ_OFS_EVT_GATE, m_eg);
    rd_chk(CFAIRQ_OFS_EVT_GATE, m_eg);
    m_fg = rnd();
    cfairq_host_inst.wr(CFAIRQ_OFS_FLT_GATE, m_fg);
    rd_chk(CFAIRQ_OFS_FLT_GATE, m_fg);
    cfairq_host_inst.wr(CFAIRQ_OFS_FLT_LIVE, 8'hff);
    // Pointer steps on within one transfer, both ways
    m_fg = rnd();
    cfairq_host_inst.wr_pair(CFAIRQ_OFS_FLT_LATCH, 8'hff, m_fg);
    cfairq_host_inst.rd_pair(CFAIRQ_OFS_FLT_LATCH, v, f);
    `CHK(v, 8'h00)
    `CHK(f, m_fg)
    rd_chk(CFAIRQ_OFS_FLT_LIVE, 8'h00);
    // Register reset command clears both gates
    @(posedge clk_sys);
    reg_rst_req <= 1'b1;
    @(posedge clk_sys);
    reg_rst_req <= 1'b0;
    m_eg = 8'h00;
    m_fg = 8'h00;
    rd_chk(CFAIRQ_OFS_EVT_GATE, m_eg);
    rd_chk(CFAIRQ_OFS_FLT_GATE, m_fg);
    // Each event gate bit masks its own event only
    for (int i = 0; i < 8; i++) begin
      m_eg = 8'h01 << i;
      cfairq_host_inst.wr(CFAIRQ_OFS_EVT_GATE, m_eg);
      evt(m_eg, 1'b0);
      irq_chk();
      evt(rnd() | ~m_eg, 1'b0);
      irq_chk();
      evt(8'hff, 1'b1);
      irq_chk();
    end
    // Random faults under a random fault gate
    for (int k = 0; k < 4; k++) begin
      m_fg = rnd();
      f = rnd();
      cfairq_host_inst.wr(CFAIRQ_OFS_FLT_GATE, m_fg);
      @(posedge clk_sys);
      fault_raw <= f;
      tk(6);
      m_lat |= f;
      irq_chk();
      rd_chk(CFAIRQ_OFS_FLT_LIVE, f);
      // A read while the fault stands leaves it latched
      rd_chk(CFAIRQ_OFS_FLT_LATCH, m_lat);
      fault_raw <= 8'h00;
      tk(4);
      rd_chk(CFAIRQ_OFS_FLT_LIVE, 8'h00);
      irq_chk();
      rd_chk(CFAIRQ_OFS_FLT_LATCH, m_lat);
      m_lat = 8'h00;
      irq_chk();
      rd_chk(CFAIRQ_OFS_FLT_LATCH, 8'h00);
    end
    `CHK(cfairq_host_inst.nacks, 0)
    results();
  end
endmodule
